// ==== hw/rtcta_pkg.sv ====
// rtcta_pkg: constants, register indices and carrier types of the rtc timer/alarm block
// assumes a 200 MHz pclk and an 8-bit register space reached through apb word slots
package rtcta_pkg;
   localparam int unsigned CLK_MHZ            = 200;
   localparam int unsigned MCD_TIMEOUT_US     = 100;
   localparam int unsigned MCD_TIMEOUT_CYCLES = MCD_TIMEOUT_US * CLK_MHZ;
   localparam int unsigned MCD_CNT_W          = 16;

   // register index; byte address is four times the index
   localparam logic [3:0] IDX_CAPTURE0 = 4'h0;
   localparam logic [3:0] IDX_CONTROL  = 4'h4;
   localparam logic [3:0] IDX_ALARM0   = 4'h8;
   localparam int unsigned ADDR_W      = 6;

   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [31:0] CAPTURE_RESET = 32'h0000_0000;
   localparam logic [31:0] ALARM_RESET   = 32'h0000_0000;

   // control register layout, bit 7 first
   typedef struct packed {
      logic osc_enable;
      logic missing_clock_detect_enable;
      logic osc_fail_flag;
      logic timer_run;
      logic alarm_enable;
      logic alarm_flag_autoreset;
      logic timer_load_request;
      logic timer_snapshot_request;
   } rtcta_ctrl_t;

   // command bundle from the control logic to the timer
   typedef struct packed {
      logic        run;
      logic        load;
      logic        clear;
      logic [31:0] load_value;
   } rtcta_tcmd_t;
endpackage

// ==== hw/rtcta_timer.sv ====
// rtcta_timer: 32-bit oscillator-paced counter with load, clear and run
// assumes tick is a one-cycle pulse per slow oscillator cycle
`timescale 1ns/1ps
`default_nettype none
module rtcta_timer (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 tick,
   input  wire rtcta_pkg::rtcta_tcmd_t cmd,
   output logic [31:0]               count
);
   logic [31:0] count_reg;
   logic [31:0] count_next;

   // load beats clear beats increment; the sum wraps at 32 bits
   always_comb begin
      count_next = count_reg;
      if (tick) begin
         if (cmd.load) begin
            count_next = cmd.load_value;
         end else if (cmd.clear) begin
            count_next = 32'h0000_0000;
         end else if (cmd.run) begin
            count_next = count_reg + 32'h0000_0001; // R01 R05
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 32'h0000_0000;
      end else begin
         count_reg <= count_next;
      end
   end

   assign count = count_reg;
endmodule
`default_nettype wire

// ==== hw/rtcta_mcd.sv ====
// rtcta_mcd: missing oscillator clock detector, fires once per stuck period
// assumes osc_level is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module rtcta_mcd #(
   parameter int unsigned TIMEOUT_CYCLES = rtcta_pkg::MCD_TIMEOUT_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic enable,
   input  wire logic osc_level,
   output logic      fail
);
   localparam logic [rtcta_pkg::MCD_CNT_W-1:0] LIMIT =
      rtcta_pkg::MCD_CNT_W'(TIMEOUT_CYCLES);

   logic                           level_reg;
   logic [rtcta_pkg::MCD_CNT_W-1:0] cnt_reg;
   logic                           fail_reg;
   logic                           changed;
   logic                           expired;

   assign changed = level_reg != osc_level;
   assign expired = enable && !changed && (cnt_reg == LIMIT);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_reg <= 1'b0;
         cnt_reg   <= '0;
         fail_reg  <= 1'b0;
      end else begin
         level_reg <= osc_level;
         fail_reg  <= expired;
         // saturate past the limit so the pulse is one-shot
         if (!enable || changed) begin
            cnt_reg <= '0;
         end else if (cnt_reg <= LIMIT) begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   assign fail = fail_reg;
endmodule
`default_nettype wire

// ==== hw/rtcta_top.sv ====
// rtcta_top: apb slave, control register, capture/alarm bytes and alarm logic
// assumes osc_clk_in is a slow oscillator level synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01 - while running, timer counts up once per slow oscillator cycle
// R02 - alarm event when timer equals alarm match value exactly
// R03 - auto-reset clears timer one oscillator cycle after alarm deasserts
// R04 - detector enabled: stuck oscillator over 100 us sets fail flag
// R05 - timer and compare wrap at 32 bits alike
// R06 - perpetual use: software advances the match value after each alarm
// R07 - counter use: hardware zeroes timer after each alarm, match value kept
// R08 - counter use: software sets interval once and counts alarms
// R09 - control bit 7 enables the oscillator
// R10 - control bit 6 enables the missing clock detector
// R11 - control bit 5 set by hardware on missing clock, cleared by software
// R12 - control bit 4 runs the timer; cleared holds the count
// R13 - control bit 3 enables alarms; writing it clears alarm flag
// R14 - reading control bit 2 returns the alarm flag
// R15 - writing control bit 2 sets auto-reset, not the flag
// R16 - bit 1 loads capture bytes into timer, cleared when done
// R17 - bit 0 snapshots timer into capture bytes, cleared when done
// R18 - alarm flag lasts at most one oscillator cycle
module rtcta_top #(
   parameter int unsigned MCD_TIMEOUT_CYCLES = rtcta_pkg::MCD_TIMEOUT_CYCLES
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [rtcta_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                  pwdata,
   output logic [31:0]                       prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic                         osc_clk_in,
   output logic                              osc_enable,
   output logic                              missing_clock_detect_enable,
   output logic                              osc_fail_flag,
   output logic                              alarm_event
);
   // ==========================================================
   // state
   rtcta_pkg::rtcta_ctrl_t ctrl_reg;
   rtcta_pkg::rtcta_ctrl_t ctrl_next;
   logic [31:0]            capture_reg;
   logic [31:0]            capture_next;
   logic [31:0]            alarm_reg;
   logic [31:0]            alarm_next;
   logic                   autoreset_reg;
   logic                   autoreset_next;
   logic                   reset_pend_reg;
   logic                   reset_pend_next;
   logic                   osc_prev_reg;
   logic [31:0]            prdata_reg;
   logic                   pready_reg;
   logic                   pslverr_reg;

   // ==========================================================
   // apb decode
   wire [3:0] idx     = paddr[5:2];
   wire       aligned = paddr[1:0] == 2'b00;
   wire       sel_cap = aligned && idx[3:2] == rtcta_pkg::IDX_CAPTURE0[3:2];
   wire       sel_ctl = aligned && idx == rtcta_pkg::IDX_CONTROL;
   wire       sel_alm = aligned && idx[3:2] == rtcta_pkg::IDX_ALARM0[3:2];
   wire       hit     = sel_cap || sel_ctl || sel_alm;
   wire       setup   = psel && !penable;
   wire       wr_en   = psel && penable && pready_reg && pwrite && hit;
   wire       wr_cap  = wr_en && sel_cap;
   wire       wr_ctl  = wr_en && sel_ctl;
   wire       wr_alm  = wr_en && sel_alm;
   wire [4:0] lane    = {idx[1:0], 3'b000};
   wire rtcta_pkg::rtcta_ctrl_t wdat = rtcta_pkg::rtcta_ctrl_t'(pwdata[7:0]);

   // ==========================================================
   // oscillator tick and sub-blocks
   wire         tick = ctrl_reg.osc_enable && osc_clk_in && !osc_prev_reg; // R09
   wire [31:0]  timer_count;
   wire         mcd_fail;
   wire         match;
   wire rtcta_pkg::rtcta_tcmd_t tcmd;

   assign tcmd.run        = ctrl_reg.timer_run;          // R12
   assign tcmd.load       = ctrl_reg.timer_load_request; // R16
   assign tcmd.clear      = reset_pend_reg;              // R07
   assign tcmd.load_value = capture_reg;

   // one event per match; the flag drops on the next oscillator cycle
   assign match = ctrl_reg.alarm_enable && !ctrl_reg.alarm_flag_autoreset
                  && timer_count == alarm_reg; // R02 R05

   rtcta_timer u_timer (
      .clk   (pclk),
      .rst_n (presetn),
      .tick  (tick),
      .cmd   (tcmd),
      .count (timer_count)
   );

   rtcta_mcd #(
      .TIMEOUT_CYCLES (MCD_TIMEOUT_CYCLES)
   ) u_mcd (
      .clk       (pclk),
      .rst_n     (presetn),
      .enable    (ctrl_reg.missing_clock_detect_enable), // R10
      .osc_level (osc_clk_in),
      .fail      (mcd_fail)
   );

   // ==========================================================
   // register next state
   always_comb begin
      ctrl_next       = ctrl_reg;
      capture_next    = capture_reg;
      alarm_next      = alarm_reg;
      autoreset_next  = autoreset_reg;
      reset_pend_next = reset_pend_reg;
      // transfers finish on an oscillator cycle
      if (tick) begin
         ctrl_next.timer_load_request = 1'b0; // R16
         if (ctrl_reg.timer_snapshot_request) begin
            capture_next                     = timer_count; // R17
            ctrl_next.timer_snapshot_request = 1'b0;
         end
         reset_pend_next = autoreset_reg && ctrl_reg.alarm_flag_autoreset; // R03
      end
      if (wr_cap) begin
         capture_next[lane +: 8] = pwdata[7:0];
      end
      if (wr_alm) begin
         alarm_next[lane +: 8] = pwdata[7:0];
      end
      if (wr_ctl) begin
         ctrl_next.osc_enable                  = wdat.osc_enable;
         ctrl_next.missing_clock_detect_enable = wdat.missing_clock_detect_enable;
         ctrl_next.timer_run                   = wdat.timer_run;
         ctrl_next.alarm_enable                = wdat.alarm_enable;
         ctrl_next.alarm_flag_autoreset        = 1'b0; // R13
         autoreset_next                        = wdat.alarm_flag_autoreset; // R15
         if (!wdat.osc_fail_flag) begin
            ctrl_next.osc_fail_flag = 1'b0; // R11
         end
         if (wdat.timer_load_request) begin
            ctrl_next.timer_load_request = 1'b1;
         end
         if (wdat.timer_snapshot_request) begin
            ctrl_next.timer_snapshot_request = 1'b1;
         end
      end
      // hardware events win over a software clear in the same cycle
      if (tick) begin
         ctrl_next.alarm_flag_autoreset = match; // R18
      end
      if (mcd_fail) begin
         ctrl_next.osc_fail_flag = 1'b1; // R04 R11
      end
   end

   // ==========================================================
   // read mux
   wire [31:0] rd_cap = {24'h00_0000, capture_reg[lane +: 8]};
   wire [31:0] rd_alm = {24'h00_0000, alarm_reg[lane +: 8]};
   wire [31:0] rd_ctl = {24'h00_0000, ctrl_reg}; // R14
   wire [31:0] rd_val = sel_cap ? rd_cap :
                        sel_ctl ? rd_ctl :
                        sel_alm ? rd_alm : 32'h0000_0000;

   // ==========================================================
   // flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg       <= rtcta_pkg::CONTROL_RESET;
         capture_reg    <= rtcta_pkg::CAPTURE_RESET;
         alarm_reg      <= rtcta_pkg::ALARM_RESET;
         autoreset_reg  <= 1'b0;
         reset_pend_reg <= 1'b0;
         osc_prev_reg   <= 1'b0;
      end else begin
         ctrl_reg       <= ctrl_next;
         capture_reg    <= capture_next;
         alarm_reg      <= alarm_next;
         autoreset_reg  <= autoreset_next;
         reset_pend_reg <= reset_pend_next;
         osc_prev_reg   <= osc_clk_in;
      end
   end

   // one access cycle: answer is ready as the access phase opens
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup && !hit;
         if (setup) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : rd_val;
         end
      end
   end

   assign prdata                      = prdata_reg;
   assign pready                      = pready_reg;
   assign pslverr                     = pslverr_reg;
   assign osc_enable                  = ctrl_reg.osc_enable;
   assign missing_clock_detect_enable = ctrl_reg.missing_clock_detect_enable;
   assign osc_fail_flag               = ctrl_reg.osc_fail_flag;
   assign alarm_event                 = ctrl_reg.alarm_flag_autoreset;

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wire quiet = !ctrl_reg.timer_load_request && !reset_pend_reg;

   sequence s_alarm_drop;
      tick && alarm_event && autoreset_reg && !wr_ctl;
   endsequence

   sequence s_zero_due;
      tick && reset_pend_reg && !ctrl_reg.timer_load_request;
   endsequence

   AST_TIMER_INC: assert property ( // R01
      tick && ctrl_reg.timer_run && quiet |=> timer_count == $past(timer_count) + 32'h1)
      else $error("timer did not advance on oscillator cycle");

   AST_TIMER_WRAP: assert property ( // R05
      tick && ctrl_reg.timer_run && quiet && timer_count == 32'hffff_ffff
      |=> timer_count == 32'h0)
      else $error("timer did not wrap to zero");

   AST_TIMER_HOLD: assert property ( // R12
      !ctrl_reg.timer_run && quiet |=> $stable(timer_count))
      else $error("stopped timer changed");

   AST_ALARM_SET: assert property ( // R02
      tick && match |=> alarm_event)
      else $error("alarm event missed on match");

   AST_ALARM_SHORT: assert property ( // R18
      alarm_event && tick |=> !alarm_event)
      else $error("alarm flag held past one oscillator cycle");

   AST_AUTORESET: assert property ( // R03
      s_alarm_drop |=> reset_pend_reg && !alarm_event)
      else $error("auto-reset not scheduled after alarm drop");

   AST_AUTOZERO: assert property ( // R07
      s_zero_due |=> timer_count == 32'h0)
      else $error("timer not zeroed by auto-reset");

   AST_FAIL_SET: assert property ( // R04
      mcd_fail |=> osc_fail_flag ##1 osc_fail_flag || $past(wr_ctl))
      else $error("oscillator fail not flagged");

   AST_CTL_WRITE: assert property ( // R13
      wr_ctl && !tick |=> !alarm_event
      && autoreset_reg == $past(wdat.alarm_flag_autoreset))
      else $error("control write did not clear flag or store auto-reset");

   AST_ENABLES: assert property ( // R09
      wr_ctl |=> osc_enable == $past(wdat.osc_enable)
      && missing_clock_detect_enable == $past(wdat.missing_clock_detect_enable))
      else $error("enable bits not stored");

   AST_LOAD: assert property ( // R16
      tick && ctrl_reg.timer_load_request && !wr_ctl
      |=> timer_count == $past(capture_reg) && !ctrl_reg.timer_load_request)
      else $error("timer load incomplete");

   AST_SNAP: assert property ( // R17
      tick && ctrl_reg.timer_snapshot_request && !wr_ctl && !wr_cap
      |=> capture_reg == $past(timer_count) && !ctrl_reg.timer_snapshot_request)
      else $error("timer snapshot incomplete");

   AST_FAIL_STICKY: assert property ( // R11
      osc_fail_flag && !(wr_ctl && !wdat.osc_fail_flag) |=> osc_fail_flag)
      else $error("oscillator fail flag dropped without a clear");

   AST_MCD_OFF: assert property ( // R10
      !missing_clock_detect_enable |=> !mcd_fail)
      else $error("detector fired while disabled");

   AST_ALARM_OFF: assert property ( // R13
      tick && !ctrl_reg.alarm_enable |=> !alarm_event)
      else $error("alarm event while alarms disabled");

   AST_REQ_HOLD: assert property ( // R16
      !tick && !wr_ctl |=> $stable(ctrl_reg.timer_load_request)
      && $stable(ctrl_reg.timer_snapshot_request))
      else $error("transfer request changed without tick or write");

   AST_READ_CTRL: assert property ( // R14
      setup && sel_ctl && !pwrite |=> prdata == {24'h00_0000, $past(ctrl_reg)})
      else $error("control read data wrong");
endmodule
`default_nettype wire

// ==== sim/tb_rtc_timer_alarm_control.sv ====
// tb_rtc_timer_alarm_control: self-checking bench for rtcta_top over apb
// assumes rtcta_pkg and the hw sources are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_timer_alarm_control;
   // ==========================================================
   // clock, reset and design
   localparam logic [5:0] A_CAP  = 6'h00;
   localparam logic [5:0] A_CTRL = 6'h10;
   localparam logic [5:0] A_ALM  = 6'h20;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [5:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        osc_clk_in;
   logic        osc_enable;
   logic        missing_clock_detect_enable;
   logic        osc_fail_flag;
   logic        alarm_event;
   int          mismatches;
   int          n_checks;
   logic [31:0] d;
   logic [31:0] snap;
   logic        e;

   rtcta_top #(.MCD_TIMEOUT_CYCLES(20)) dut (
      .pclk                        (pclk),
      .presetn                     (presetn),
      .psel                        (psel),
      .penable                     (penable),
      .pwrite                      (pwrite),
      .paddr                       (paddr),
      .pwdata                      (pwdata),
      .prdata                      (prdata),
      .pready                      (pready),
      .pslverr                     (pslverr),
      .osc_clk_in                  (osc_clk_in),
      .osc_enable                  (osc_enable),
      .missing_clock_detect_enable (missing_clock_detect_enable),
      .osc_fail_flag               (osc_fail_flag),
      .alarm_event                 (alarm_event)
   );

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ==========================================================
   // apb master and helpers
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      logic [31:0] rd;
      logic        err;
      xfer(1'b1, a, {24'h0, v}, rd, err);
   endtask

   task automatic rd8(input logic [5:0] a, output logic [31:0] v);
      logic err;
      xfer(1'b0, a, 32'h0, v, err);
   endtask

   task automatic wr_word(input logic [5:0] base, input logic [31:0] v);
      for (int i = 0; i < 4; i++) wr(base + 6'(4 * i), v[8*i +: 8]);
   endtask

   task automatic rd_word(input logic [5:0] base, output logic [31:0] v);
      logic [31:0] b;
      for (int i = 0; i < 4; i++) begin
         rd8(base + 6'(4 * i), b);
         v[8*i +: 8] = b[7:0];
      end
   endtask

   // one oscillator cycle: rising level, then low again
   task automatic tick();
      @(posedge pclk);
      osc_clk_in <= 1'b1;
      repeat (3) @(posedge pclk);
      osc_clk_in <= 1'b0;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      conclude();
   end

   // ==========================================================
   // tests
   initial begin
      mismatches = 0;
      n_checks   = 0;
      presetn    = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 6'h00;
      pwdata     = 32'h0;
      osc_clk_in = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;

      xfer(1'b0, A_CTRL, 32'h0, d, e);
      chk("control reset", 32'h0000_0000, d);
      chk("mapped err", 32'h0, {31'h0, e});
      rd_word(A_CAP, d);
      chk("capture reset", 32'h0000_0000, d);
      rd_word(A_ALM, d);
      chk("alarm reset", 32'h0000_0000, d);
      xfer(1'b0, 6'h14, 32'h0, d, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, d);
      xfer(1'b0, 6'h01, 32'h0, d, e);
      chk("unaligned err", 32'h1, {31'h0, e});
      $display("test reset_map done");

      wr_word(A_CAP, 32'h1234_5678);
      wr(A_CTRL, 8'h92);
      @(negedge pclk);
      chk("osc_enable", 32'h1, {31'h0, osc_enable});
      rd8(A_CTRL, d);
      chk("load pending", 32'h92, d);
      tick();
      rd8(A_CTRL, d);
      chk("load done", 32'h90, d);
      repeat (3) tick();
      wr(A_CTRL, 8'h91);
      rd8(A_CTRL, d);
      chk("snapshot pending", 32'h91, d);
      tick();
      rd8(A_CTRL, d);
      chk("snapshot done", 32'h90, d);
      rd_word(A_CAP, d);
      chk("count after load", 32'h1234_567b, d);
      wr(A_CTRL, 8'h81);
      tick();
      rd_word(A_CAP, snap);
      chk("stopped snapshot", 32'h1234_567c, snap);
      repeat (3) tick();
      wr(A_CTRL, 8'h81);
      tick();
      rd_word(A_CAP, d);
      chk("stopped count", 32'h1234_567c, d);
      $display("test load_snapshot_run done");

      wr_word(A_CAP, 32'hffff_fffe);
      wr_word(A_ALM, 32'h0000_0000);
      wr(A_CTRL, 8'h92);
      tick();
      wr(A_CTRL, 8'h98);
      repeat (2) tick();
      chk("no early alarm", 32'h0, {31'h0, alarm_event});
      tick();
      chk("alarm at wrap", 32'h1, {31'h0, alarm_event});
      rd8(A_CTRL, d);
      chk("flag readback", 32'h9c, d);
      wr(A_CTRL, 8'h98);
      @(negedge pclk);
      chk("flag cleared by write", 32'h0, {31'h0, alarm_event});
      $display("test wrap_alarm done");

      wr_word(A_CAP, 32'h0);
      wr_word(A_ALM, 32'h3);
      wr(A_CTRL, 8'h92);
      tick();
      wr(A_CTRL, 8'h9c);
      rd8(A_CTRL, d);
      chk("autoreset not flag", 32'h98, d);
      for (int n = 1; n <= 10; n++) begin
         tick();
         chk("alarm sequence", {31'h0, n == 4 || n == 10}, {31'h0, alarm_event});
      end
      rd_word(A_ALM, d);
      chk("match kept", 32'h3, d);
      $display("test auto_reset done");

      // timer stands at 4; software moves the match value on by 3 after each alarm
      wr(A_CTRL, 8'h98);
      wr(A_ALM, 8'h06);
      for (int n = 1; n <= 6; n++) begin
         tick();
         chk("perpetual alarm", {31'h0, n == 3 || n == 6}, {31'h0, alarm_event});
         if (n == 3) wr(A_ALM, 8'h09);
      end
      $display("test perpetual done");

      wr(A_CTRL, 8'h40);
      @(negedge pclk);
      chk("mcd enable", 32'h1, {31'h0, missing_clock_detect_enable});
      repeat (12) @(posedge pclk);
      @(negedge pclk);
      chk("no early fail", 32'h0, {31'h0, osc_fail_flag});
      repeat (20) @(posedge pclk);
      @(negedge pclk);
      chk("fail set", 32'h1, {31'h0, osc_fail_flag});
      wr(A_CTRL, 8'h20);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk("fail sticky", 32'h1, {31'h0, osc_fail_flag});
      wr(A_CTRL, 8'h00);
      repeat (60) @(posedge pclk);
      @(negedge pclk);
      chk("fail cleared", 32'h0, {31'h0, osc_fail_flag});
      $display("test missing_clock done");
      conclude();
   end
endmodule
`default_nettype wire
